// *** verilog/estop_ready_handshake.sv ***
// power-on and emergency-stop handshake of the ready output
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R1] any hazardous fault drops ready_output, opening the stop loop
// [R2] self-test sequence runs after every reset (line power on)
// [R3] first state waits for control voltage, flagging missing voltage
// [R4] ready_output drops within 66 ms of control voltage detected
// [R5] ack must go low within 1 s of dropping, else defect fault
// [R6] external relay chain answers ready changes within 1 s
// [R7] ready_output rises within 20 ms of ack going low
// [R8] normal operation only when ready_output and ack both high
// [R9] control voltage loss in normal operation flags emergency stop
// [R10] after external stop, voltage return resumes without self-test
// [R11] exceeded limit reports error and commands machine stop
// [R12] position supervision only while position loop is closed
// [R13] defect fault latches with ready low until next power-on
module estop_ready_handshake #(
    parameter int unsigned DROP_CYCLES = estop_pkg::DROP_CYC,
    parameter int unsigned ACK_TIMEOUT_CYCLES = estop_pkg::ACK_TIMEOUT_CYC,
    parameter int unsigned RAISE_CYCLES = estop_pkg::RAISE_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // relay chain
    input wire logic ready_ack_input_i,
    output logic ready_output_o,
    // fault sources
    input wire logic hazard_fault_i,
    input wire logic limit_exceeded_i,
    input wire logic pos_error_i,
    input wire logic pos_loop_closed_i,
    // status
    output logic volt_missing_o,
    output logic estop_o,
    output logic estop_defect_o,
    output logic defect_event_o,
    output logic error_o,
    output logic machine_stop_o,
    output logic normal_op_o,
    output var estop_pkg::seq_state_type state_o
);
    import estop_pkg::*;

    sync_if sif ();
    assign sif.ack_raw = ready_ack_input_i;
    input_sync u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .s(sif)
    );
    logic ack;
    assign ack = sif.ack_sync;

    localparam int unsigned FAULT_SRC_N = 3;

    // sequencer group
    seq_state_type state;
    seq_state_type next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic ack_timeout;
    // ready output group
    logic ready;
    logic next_ready;
    // sticky error group
    logic err;
    logic next_err;
    // defect event group
    logic defect_ev;
    logic next_defect_ev;
    // qualified fault sources
    logic [FAULT_SRC_N-1:0] fault_src;
    logic [FAULT_SRC_N-1:0] fault_qual;
    logic [FAULT_SRC_N-1:0] fault_vec;
    logic fault;

    assign fault_src = {hazard_fault_i, limit_exceeded_i, pos_error_i};
    // position errors only count while the loop is closed
    assign fault_qual = {1'b1, 1'b1, pos_loop_closed_i}; // [R12]
    for (genvar i = 0; i < FAULT_SRC_N; i++) begin : g_fault
        assign fault_vec[i] = fault_src[i] & fault_qual[i];
    end
    assign fault = |fault_vec; // [R1] [R11]

    // one cycle short of the limit, the state change itself costs a cycle
    assign ack_timeout = (timer >= TIMER_W'(ACK_TIMEOUT_CYCLES) - TIMER_W'(1)); // [R5]

    always_comb begin
        next_state = state;
        next_timer = timer + TIMER_W'(1);
        case (state)
            ST_WAIT_VOLT: begin
                next_timer = '0;
                if (ack) begin
                    next_state = ST_DROP; // [R3]
                end
            end
            ST_DROP: begin
                // dropping at once leaves ample margin inside the limit
                next_timer = '0;
                next_state = ST_WAIT_ACK_LOW; // [R4]
                if (timer >= TIMER_W'(DROP_CYCLES)) begin
                    next_state = ST_WAIT_ACK_LOW;
                end
            end
            ST_WAIT_ACK_LOW: begin
                // relies on the relay chain answering within its own limit [R6]
                if (!ack) begin
                    next_state = ST_RAISE;
                    next_timer = '0;
                end else if (ack_timeout) begin
                    next_state = ST_DEFECT; // [R5]
                end
            end
            ST_RAISE: begin
                next_state = ST_WAIT_RUN; // [R7]
                if (timer >= TIMER_W'(RAISE_CYCLES)) begin
                    next_state = ST_WAIT_RUN;
                end
            end
            ST_WAIT_RUN: begin
                if (ready && ack) begin
                    next_state = ST_RUN; // [R8]
                end
            end
            ST_RUN: begin
                if (!ack) begin
                    next_state = ST_ESTOP; // [R9]
                end
            end
            ST_ESTOP: begin
                if (ack) begin
                    next_state = ST_RUN; // [R10]
                end
            end
            ST_DEFECT: begin
                // held until the next power-on
                next_state = ST_DEFECT; // [R13]
            end
            default: begin
                next_state = ST_WAIT_VOLT;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state <= ST_WAIT_VOLT; // [R2]
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ready starts high so that the power-on drop is a real test of the loop
    always_comb begin
        next_ready = ready;
        case (state)
            ST_DROP: begin
                next_ready = 1'b0; // [R4]
            end
            ST_RAISE: begin
                next_ready = 1'b1; // [R7]
            end
            ST_DEFECT: begin
                next_ready = 1'b0; // [R13]
            end
            default: begin
                next_ready = ready;
            end
        endcase
        // faults override the sequence on every cycle
        if (fault) begin
            next_ready = 1'b0; // [R1]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ready <= 1'b1;
        end else begin
            ready <= next_ready;
        end
    end

    // sticky, only a power-on clears it
    always_comb begin
        next_err = err;
        if (fault) begin
            next_err = 1'b1; // [R11]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            err <= 1'b0;
        end else begin
            err <= next_err;
        end
    end

    // one pulse on the way into the defect state
    always_comb begin
        next_defect_ev = (state == ST_WAIT_ACK_LOW) && ack && ack_timeout; // [R13]
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            defect_ev <= 1'b0;
        end else begin
            defect_ev <= next_defect_ev;
        end
    end

    assign ready_output_o = ready;
    assign volt_missing_o = (state == ST_WAIT_VOLT) || (state == ST_WAIT_RUN && !ack); // [R3]
    assign estop_o = (state == ST_ESTOP); // [R9]
    assign estop_defect_o = (state == ST_DEFECT); // [R13]
    assign defect_event_o = defect_ev;
    assign error_o = err;
    assign machine_stop_o = err || (state != ST_RUN); // [R11]
    assign normal_op_o = (state == ST_RUN) && !err;
    assign state_o = state;
endmodule : estop_ready_handshake
`default_nettype wire

// *** common/estop_pkg.sv ***
// shared constants and types of the emergency-stop handshake
package estop_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned DROP_MS = 66;
    localparam int unsigned ACK_TIMEOUT_MS = 1000;
    localparam int unsigned RAISE_MS = 20;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // drop and raise times round down, minus one cycle so the limit is strictly met
    localparam int unsigned DROP_CYC = DROP_MS * CYC_PER_MS - 1;
    localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_MS * CYC_PER_MS;
    localparam int unsigned RAISE_CYC = RAISE_MS * CYC_PER_MS - 1;
    localparam int unsigned TIMER_W = 32;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    typedef enum logic [2:0] {
        ST_WAIT_VOLT,
        ST_DROP,
        ST_WAIT_ACK_LOW,
        ST_RAISE,
        ST_WAIT_RUN,
        ST_RUN,
        ST_ESTOP,
        ST_DEFECT
    } seq_state_type;
endpackage : estop_pkg

// *** common/sync_if.sv ***
// carrier between the top and its input synchroniser
`timescale 1ns/1ns
`default_nettype none
interface sync_if;
    logic ack_raw;
    logic ack_sync;
    modport top (output ack_raw, input ack_sync);
    modport syn (input ack_raw, output ack_sync);
endinterface : sync_if
`default_nettype wire

// *** verilog/input_sync.sv ***
// two-flop synchroniser for the acknowledgment pin
`timescale 1ns/1ns
`default_nettype none
module input_sync (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // signals
    sync_if.syn s
);
    import estop_pkg::*;
    logic [1:0] stage;
    logic [1:0] next_stage;
    always_comb begin
        next_stage = {stage[0], s.ack_raw};
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            stage <= SYNC_RESET;
        end else begin
            stage <= next_stage;
        end
    end
    assign s.ack_sync = stage[1];
endmodule : input_sync
`default_nettype wire

// *** sim/relay_chain_model.sv ***
// relay chain model answering the ready output
`timescale 1ns/1ns
`default_nettype none
module relay_chain_model #(parameter int LAT = 2) (
    input wire logic clk_i, volt_i, ready_i, stuck_i,
    output logic ack_o
);
    logic [7:0] hist = 8'h00;
    // contacts follow ready after LAT+1 cycles, far inside 1 s
    always @(posedge clk_i) hist <= {hist[6:0], ready_i};
    // stuck models welded contacts
    assign ack_o = stuck_i | (volt_i & hist[LAT]);
endmodule : relay_chain_model
`default_nettype wire

// *** sim/estop_ready_handshake_asserts.sv ***
// concurrent checks of the ready handshake
`timescale 1ns/1ns
`default_nettype none
module estop_ready_handshake_asserts import estop_pkg::*; (
    input wire logic core_clk_i, reset_n_i, ready_ack_input_i, ready_output_o,
    input wire logic hazard_fault_i, limit_exceeded_i, pos_error_i, pos_loop_closed_i,
    input wire logic volt_missing_o, estop_o, estop_defect_o, defect_event_o,
    input wire logic error_o, machine_stop_o, normal_op_o,
    input var seq_state_type state_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_drop; state_o == ST_DROP |=> !ready_output_o; endproperty
    a_drop: assert property (p_drop) else $error("ready kept");
    property p_raise; state_o == ST_RAISE |=> ready_output_o || error_o; endproperty
    a_raise: assert property (p_raise) else $error("ready not raised");
    property p_haz; hazard_fault_i |=> !ready_output_o && error_o; endproperty
    a_haz: assert property (p_haz) else $error("loop not opened");
    property p_lim; limit_exceeded_i |=> error_o && machine_stop_o; endproperty
    a_lim: assert property (p_lim) else $error("no stop");
    property p_pos; !(pos_loop_closed_i || hazard_fault_i || limit_exceeded_i || error_o)
        |=> !error_o; endproperty
    a_pos: assert property (p_pos) else $error("open loop error");
    property p_volt; state_o == ST_WAIT_VOLT |-> volt_missing_o && machine_stop_o && !normal_op_o;
    endproperty
    a_volt: assert property (p_volt) else $error("no missing flag");
    property p_defect; estop_defect_o |=> estop_defect_o && !ready_output_o; endproperty
    a_defect: assert property (p_defect) else $error("defect lost");
    property p_run; $rose(normal_op_o) |-> ready_output_o && !machine_stop_o; endproperty
    a_run: assert property (p_run) else $error("bad run entry");
    property p_event; defect_event_o |-> estop_defect_o && !ready_output_o; endproperty
    a_event: assert property (p_event) else $error("event without defect");
    property p_estop; estop_o |-> !normal_op_o && machine_stop_o; endproperty
    a_estop: assert property (p_estop) else $error("running in stop");
    c_run: cover property (state_o == ST_RUN);
    c_stop: cover property (estop_o);
    c_def: cover property (defect_event_o);
    c_err: cover property (error_o);
endmodule : estop_ready_handshake_asserts
bind estop_ready_handshake estop_ready_handshake_asserts chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ready_ack_input_i(ready_ack_input_i),
    .ready_output_o(ready_output_o), .hazard_fault_i(hazard_fault_i),
    .limit_exceeded_i(limit_exceeded_i), .pos_error_i(pos_error_i),
    .pos_loop_closed_i(pos_loop_closed_i), .volt_missing_o(volt_missing_o), .estop_o(estop_o),
    .estop_defect_o(estop_defect_o), .defect_event_o(defect_event_o), .error_o(error_o),
    .machine_stop_o(machine_stop_o), .normal_op_o(normal_op_o), .state_o(state_o));
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench of the ready handshake
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import estop_pkg::*;
    logic core_clk_i = 0, reset_n_i = 0, hazard_fault_i = 0, limit_exceeded_i = 0;
    logic pos_error_i = 0, pos_loop_closed_i = 0, ready_ack_input_i, ready_output_o;
    logic [2:0] watch;
    localparam int RDY_LOW = 0, RUN_UP = 1, DEF_EV = 2;
    logic volt_missing_o, estop_o, estop_defect_o, defect_event_o, error_o;
    logic machine_stop_o, normal_op_o, volt = 0, stuck = 0;
    seq_state_type state_o;
    int n_mismatch = 0, n_tests = 0;
    // hazard, limit, pos error, loop closed, error expected
    logic [4:0] rows [6] = '{5'h00, 5'h11, 5'h09, 5'h04, 5'h07, 5'h02};
    always_comb watch = {defect_event_o, normal_op_o, !ready_output_o};
    initial forever #20 core_clk_i = ~core_clk_i;
    relay_chain_model partner (.clk_i(core_clk_i), .volt_i(volt), .ready_i(ready_output_o),
        .stuck_i(stuck), .ack_o(ready_ack_input_i));
    estop_ready_handshake #(.ACK_TIMEOUT_CYCLES(50)) dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .ready_ack_input_i(ready_ack_input_i), .ready_output_o(ready_output_o),
        .hazard_fault_i(hazard_fault_i), .limit_exceeded_i(limit_exceeded_i),
        .pos_error_i(pos_error_i), .pos_loop_closed_i(pos_loop_closed_i),
        .volt_missing_o(volt_missing_o), .estop_o(estop_o), .estop_defect_o(estop_defect_o),
        .defect_event_o(defect_event_o), .error_o(error_o), .machine_stop_o(machine_stop_o),
        .normal_op_o(normal_op_o), .state_o(state_o));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // bounded wait, a hang counts as a mismatch
    task automatic wait_hi(input int b);
        int i;
        for (i = 0; i < 200 && watch[b] !== 1'b1; i++) @(negedge core_clk_i);
        if (watch[b] !== 1'b1) begin
            n_mismatch++;
            end_of_test;
        end
    endtask : wait_hi
    task bring_up(input logic stk);
        reset_n_i = 0;
        volt = 0;
        stuck = stk;
        repeat (12) @(negedge core_clk_i);
        check(volt_missing_o, 1);
        reset_n_i = 1;
        volt = 1;
        wait_hi(RDY_LOW);
        if (!stk) begin
            wait_hi(RUN_UP);
            check(volt_missing_o, 0);
        end
    endtask : bring_up
    initial begin
        for (int r = 0; r < 6; r++) begin
            bring_up(0);
            {hazard_fault_i, limit_exceeded_i, pos_error_i, pos_loop_closed_i} = rows[r][4:1];
            repeat (2) @(negedge core_clk_i);
            check(error_o, rows[r][0]);
            check(ready_output_o, !rows[r][0]);
            check(machine_stop_o, rows[r][0]);
            {hazard_fault_i, limit_exceeded_i, pos_error_i, pos_loop_closed_i} = 4'h0;
        end
        bring_up(0);
        volt = 0;
        repeat (8) @(negedge core_clk_i);
        check(estop_o, 1);
        check(normal_op_o, 0);
        volt = 1;
        repeat (8) @(negedge core_clk_i);
        check({state_o, ready_output_o}, {ST_RUN, 1'b1});
        check(normal_op_o, 1);
        bring_up(1);
        repeat (40) @(negedge core_clk_i);
        check(estop_defect_o, 0);
        wait_hi(DEF_EV);
        check(estop_defect_o, 1);
        @(negedge core_clk_i);
        check(defect_event_o, 0);
        stuck = 0;
        repeat (20) @(negedge core_clk_i);
        check({estop_defect_o, ready_output_o}, 2'h2);
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
